// ===== hdl/fspg_pkg.sv
// Package for the flash self-program guard: register map, field layout, timing and types.
package fspg_pkg;

    // Flash geometry in 16-bit words.
    localparam int unsigned ADDR_W          = 13;
    localparam int unsigned PAGE_W          = 6;
    localparam logic [12:0] HALTING_SECTION_START_WORD = 13'h0_C00;

    // Boot-size fuse code to boot section start word.
    localparam logic [12:0] BOOT_START_00   = 13'h0_C00;
    localparam logic [12:0] BOOT_START_01   = 13'h0_E00;
    localparam logic [12:0] BOOT_START_10   = 13'h0_F00;
    localparam logic [12:0] BOOT_START_11   = 13'h0_F80;

    // Lock field encodings, 1 meaning unprogrammed.
    localparam logic [1:0]  LOCK_FREE       = 2'h3;
    localparam logic [1:0]  LOCK_NO_WRITE   = 2'h2;
    localparam logic [1:0]  LOCK_NO_RW      = 2'h0;
    localparam logic [1:0]  LOCK_NO_READ    = 2'h1;
    localparam logic [3:0]  LOCKS_RESET     = 4'hF;

    // Avalon register offsets (byte addresses) and widths.
    localparam int unsigned AV_ADDR_W       = 4;
    localparam logic [3:0]  REG_CTRL        = 4'h0;
    localparam logic [3:0]  REG_LOCK        = 4'h4;
    localparam logic [3:0]  REG_STATUS      = 4'h8;
    localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;

    // Control register bit positions.
    localparam int unsigned CTRL_STORE_EN   = 0;
    localparam int unsigned CTRL_ERASE      = 1;
    localparam int unsigned CTRL_WRITE      = 2;
    localparam int unsigned CTRL_LOCK_SET   = 3;
    localparam int unsigned CTRL_REENABLE   = 4;
    localparam int unsigned CTRL_CHIP_ERASE = 7;

    // Timing.
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned ARM_CYCLES      = 4;
    localparam int unsigned PROG_TIME_US    = 4000;
    localparam int unsigned PROG_CYCLES     = (PROG_TIME_US * (CLK_HZ / 1_000_000));
    localparam int unsigned CNT_W           = 17;

    typedef enum logic [1:0] {
        FSPG_IDLE,
        FSPG_ARMED,
        FSPG_BUSY
    } fspg_state_t;

    typedef struct packed {
        logic        store_req;
        logic        load_req;
        logic [12:0] target_word;
        logic [12:0] fetch_word;
        logic [3:0]  lock_data;
    } fspg_cpu_req_t;

    typedef struct packed {
        logic        cpu_stall;
        logic        concurrent_read_ok;
        logic        halting_read_ok;
        logic        load_denied;
        logic        irq_block;
        logic        prog_erase;
        logic        prog_write;
        logic        buffer_load;
        logic        store_ignored;
    } fspg_cpu_rsp_t;

endpackage : fspg_pkg

// ===== hdl/fspg_guard.sv
// Flash self-program guard: section decode, lock fields, busy tracking and CPU stall.
`timescale 1ns/1ps
module fspg_guard (
    // Clock and reset.
    input  wire logic                   CLK_SYS_IN,
    input  wire logic                   RESET_IN,
    // Fuses and global lock mode; only the general lock mode is ignored by self-programming.
    input  wire logic [1:0]             BOOT_SIZE_FUSES_IN,
    input  wire logic                   VECTORS_IN_BOOT_IN,
    input  wire logic [1:0]             GENERAL_LOCK_MODE_IN,
    // CPU side.
    input  wire fspg_pkg::fspg_cpu_req_t CPU_REQ_IN,
    output fspg_pkg::fspg_cpu_rsp_t     CPU_RSP_OUT,
    // Avalon-MM slave.
    input  wire logic [3:0]             AVS_ADDRESS_IN,
    input  wire logic                   AVS_READ_IN,
    input  wire logic                   AVS_WRITE_IN,
    input  wire logic [31:0]            AVS_WRITEDATA_IN,
    output logic [31:0]                 AVS_READDATA_OUT,
    output logic                        AVS_WAITREQUEST_OUT
);
    import fspg_pkg::*;

    typedef struct packed {
        fspg_state_t   state;
        logic [1:0]    arm_cnt;
        logic [CNT_W-1:0] prog_cnt;
        logic          op_erase;
        logic          op_write;
        logic          op_lock;
        logic          op_reenable;
        logic          target_halting_section;
        logic          busy_flag;
        logic [3:0]    locks;
        logic          ack;
        logic [31:0]   rdata;
        fspg_cpu_rsp_t rsp;
    } fspg_regs_t;

    fspg_regs_t s_q;
    fspg_regs_t s_d;

    // Boot section start from fuses; every choice is at or above the halting start.
    function automatic logic [12:0] boot_start(input logic [1:0] fz);
        if (fz == 2'h0) begin
            boot_start = BOOT_START_00;
        end else if (fz == 2'h1) begin
            boot_start = BOOT_START_01;
        end else if (fz == 2'h2) begin
            boot_start = BOOT_START_10;
        end else begin
            boot_start = BOOT_START_11;
        end
    endfunction

    function automatic logic in_boot(input logic [12:0] a, input logic [1:0] fz);
        in_boot = (a >= boot_start(fz));
    endfunction

    function automatic logic write_blocked(input logic [1:0] lk);
        write_blocked = (lk == LOCK_NO_WRITE) || (lk == LOCK_NO_RW);
    endfunction

    function automatic logic read_blocked(input logic [1:0] lk);
        read_blocked = (lk == LOCK_NO_RW) || (lk == LOCK_NO_READ);
    endfunction

    logic          exec_boot;
    logic          tgt_boot;
    logic          tgt_halting_section;
    logic [1:0]    app_lock;
    logic [1:0]    boot_lock;
    logic          store_ok;
    logic          load_ok;
    logic          prog_busy;
    logic          bus_hit;
    logic          ctrl_wr;

    always_comb begin
        exec_boot = in_boot(CPU_REQ_IN.fetch_word, BOOT_SIZE_FUSES_IN);
        tgt_boot  = in_boot(CPU_REQ_IN.target_word, BOOT_SIZE_FUSES_IN);
        tgt_halting_section  = (CPU_REQ_IN.target_word >= HALTING_SECTION_START_WORD);
        app_lock  = s_q.locks[1:0];
        boot_lock = s_q.locks[3:2];
        prog_busy = (s_q.state == FSPG_BUSY);
        // General lock modes are deliberately not consulted here.
        store_ok  = exec_boot &&
                    !(tgt_boot ? write_blocked(boot_lock) : write_blocked(app_lock));
        load_ok   = !(exec_boot && !tgt_boot && read_blocked(app_lock)) &&
                    !(!exec_boot && tgt_boot && read_blocked(boot_lock));
        bus_hit   = AVS_READ_IN || AVS_WRITE_IN;
        // A write lands only at the edge where waitrequest is seen low.
        ctrl_wr   = AVS_WRITE_IN && (AVS_ADDRESS_IN == REG_CTRL) && s_q.ack;
    end

    ////////////////////////////////////////////////////////////////////////////

    always_comb begin
        s_d       = s_q;
        s_d.ack   = bus_hit && !s_q.ack;
        s_d.rsp.prog_erase    = 1'b0;
        s_d.rsp.prog_write    = 1'b0;
        s_d.rsp.buffer_load   = 1'b0;
        s_d.rsp.store_ignored = 1'b0;
        s_d.rsp.load_denied   = CPU_REQ_IN.load_req && !load_ok;

        // Register reads; reads are one-cycle delayed, answered with waitrequest low.
        // Read data is captured once per access so that it stands until the next one.
        if (!(AVS_READ_IN && !s_q.ack)) begin
            s_d.rdata = s_q.rdata;
        end else if (AVS_ADDRESS_IN == REG_CTRL) begin
            s_d.rdata = {24'h00_0000, 1'b0, s_q.busy_flag, 1'b0, s_q.op_reenable,
                         s_q.op_lock, s_q.op_write, s_q.op_erase, (s_q.state != FSPG_IDLE)};
        end else if (AVS_ADDRESS_IN == REG_LOCK) begin
            s_d.rdata = {28'h000_0000, s_q.locks};
        end else if (AVS_ADDRESS_IN == REG_STATUS) begin
            s_d.rdata = {29'h0000_0000, s_q.target_halting_section, prog_busy, s_q.busy_flag};
        end else begin
            s_d.rdata = UNMAPPED_DATA;
        end

        // Chip erase in the idle state and reset alone restore lock bits.
        if (ctrl_wr && AVS_WRITEDATA_IN[CTRL_CHIP_ERASE] && s_q.state == FSPG_IDLE) begin
            s_d.locks = LOCKS_RESET;
        end

        case (s_q.state)
            FSPG_IDLE: begin
                if (ctrl_wr && AVS_WRITEDATA_IN[CTRL_STORE_EN]) begin
                    s_d.state       = FSPG_ARMED;
                    s_d.arm_cnt     = 2'(ARM_CYCLES - 1);
                    s_d.op_erase    = AVS_WRITEDATA_IN[CTRL_ERASE];
                    s_d.op_write    = AVS_WRITEDATA_IN[CTRL_WRITE];
                    s_d.op_lock     = AVS_WRITEDATA_IN[CTRL_LOCK_SET];
                    s_d.op_reenable = AVS_WRITEDATA_IN[CTRL_REENABLE];
                end
            end
            FSPG_ARMED: begin
                if (CPU_REQ_IN.store_req) begin
                    s_d.state = FSPG_IDLE;
                    s_d.op_erase    = 1'b0;
                    s_d.op_write    = 1'b0;
                    s_d.op_lock     = 1'b0;
                    s_d.op_reenable = 1'b0;
                    if (!exec_boot) begin
                        s_d.rsp.store_ignored = 1'b1;
                    end else if (s_q.op_reenable) begin
                        s_d.busy_flag = 1'b0;
                    end else if (s_q.op_lock) begin
                        // Programming only: a one cannot return a zero bit to one.
                        s_d.locks = s_q.locks & CPU_REQ_IN.lock_data;
                    end else if (!store_ok) begin
                        s_d.rsp.store_ignored = 1'b1;
                    end else if (s_q.op_erase || s_q.op_write) begin
                        s_d.state       = FSPG_BUSY;
                        s_d.op_erase    = s_q.op_erase;
                        s_d.op_write    = s_q.op_write && !s_q.op_erase;
                        s_d.prog_cnt    = CNT_W'(PROG_CYCLES - 1);
                        s_d.target_halting_section = tgt_halting_section;
                        s_d.rsp.prog_erase = s_q.op_erase;
                        s_d.rsp.prog_write = s_q.op_write && !s_q.op_erase;
                        if (!tgt_halting_section) begin
                            s_d.busy_flag = 1'b1;
                        end
                    end else begin
                        s_d.rsp.buffer_load = 1'b1;
                        s_d.busy_flag       = 1'b0;
                    end
                end else if (s_q.arm_cnt == 2'h0) begin
                    s_d.state       = FSPG_IDLE;
                    s_d.op_erase    = 1'b0;
                    s_d.op_write    = 1'b0;
                    s_d.op_lock     = 1'b0;
                    s_d.op_reenable = 1'b0;
                end else begin
                    s_d.arm_cnt = s_q.arm_cnt - 2'h1;
                end
            end
            FSPG_BUSY: begin
                if (s_q.prog_cnt == '0) begin
                    s_d.state    = FSPG_IDLE;
                    s_d.op_erase = 1'b0;
                    s_d.op_write = 1'b0;
                end else begin
                    s_d.prog_cnt = s_q.prog_cnt - CNT_W'(1);
                end
            end
            default: begin
                s_d.state = FSPG_IDLE;
            end
        endcase

        // Stall only for halting-section targets.
        s_d.rsp.cpu_stall          = (s_d.state == FSPG_BUSY) && s_d.target_halting_section;
        s_d.rsp.halting_read_ok    = !s_d.rsp.cpu_stall;
        s_d.rsp.concurrent_read_ok = !s_d.busy_flag && (s_d.state != FSPG_BUSY);
        // Interrupt masking depends on where vectors sit and who is executing.
        s_d.rsp.irq_block = (VECTORS_IN_BOOT_IN && !exec_boot && read_blocked(app_lock)) ||
                            (!VECTORS_IN_BOOT_IN && exec_boot && read_blocked(boot_lock));
    end

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            s_q       <= '0;
            s_q.state <= FSPG_IDLE;
            s_q.locks <= LOCKS_RESET;
            s_q.rsp.halting_read_ok    <= 1'b1;
            s_q.rsp.concurrent_read_ok <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign CPU_RSP_OUT         = s_q.rsp;
    assign AVS_READDATA_OUT    = s_q.rdata;
    assign AVS_WAITREQUEST_OUT = bus_hit && !s_q.ack;

endmodule : fspg_guard

// ===== testbench/fspg_guard_checker.sv
// Concurrent checks on the ports of the flash self-program guard.
`timescale 1ns/1ps
module fspg_guard_checker (
    // Clock, reset and fuses.
    input wire logic                    CLK_SYS_IN,
    input wire logic                    RESET_IN,
    input wire logic [1:0]              BOOT_SIZE_FUSES_IN,
    // CPU side.
    input wire fspg_pkg::fspg_cpu_req_t CPU_REQ_IN,
    input wire fspg_pkg::fspg_cpu_rsp_t CPU_RSP_OUT
);
    import fspg_pkg::*;
    logic [12:0] boot_start;
    logic        prog;
    always_comb begin
        case (BOOT_SIZE_FUSES_IN)
            2'h0: boot_start = BOOT_START_00;
            2'h1: boot_start = BOOT_START_01;
            2'h2: boot_start = BOOT_START_10;
            default: boot_start = BOOT_START_11;
        endcase
    end
    assign prog = CPU_RSP_OUT.prog_erase || CPU_RSP_OUT.prog_write;
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (RESET_IN);
    stall_no_read_a: assert property (
        CPU_RSP_OUT.cpu_stall |-> !CPU_RSP_OUT.halting_read_ok && !CPU_RSP_OUT.concurrent_read_ok)
        else $error("stalled CPU with readable flash");
    prog_blocks_conc_a: assert property (prog |-> !CPU_RSP_OUT.concurrent_read_ok)
        else $error("concurrent section readable at program start");
    app_store_void_a: assert property (
        CPU_REQ_IN.store_req && CPU_REQ_IN.fetch_word < boot_start |=> !prog)
        else $error("store from application code started programming");
    halt_target_stall_a: assert property (
        prog && $past(CPU_REQ_IN.target_word) >= HALTING_SECTION_START_WORD |-> CPU_RSP_OUT.cpu_stall)
        else $error("halting section programmed without stall");
    rww_keeps_run_a: assert property (
        prog && $past(CPU_REQ_IN.target_word) < HALTING_SECTION_START_WORD
        |-> !CPU_RSP_OUT.cpu_stall && CPU_RSP_OUT.halting_read_ok)
        else $error("concurrent section program stalled the CPU");
    stall_holds_a: assert property ($rose(CPU_RSP_OUT.cpu_stall) |=> CPU_RSP_OUT.cpu_stall[*8])
        else $error("stall dropped early");
    refused_quiet_a: assert property (CPU_RSP_OUT.store_ignored |-> !prog)
        else $error("refused store started programming");
    conc_block_cause_a: assert property ($fell(CPU_RSP_OUT.concurrent_read_ok) |-> prog)
        else $error("concurrent section blocked without a program start");
    cover property (CPU_RSP_OUT.prog_erase);
    cover property (CPU_RSP_OUT.cpu_stall);
    cover property (CPU_RSP_OUT.load_denied);
endmodule // fspg_guard_checker

bind fspg_guard fspg_guard_checker chk_u (.CLK_SYS_IN(CLK_SYS_IN), .RESET_IN(RESET_IN),
    .BOOT_SIZE_FUSES_IN(BOOT_SIZE_FUSES_IN), .CPU_REQ_IN(CPU_REQ_IN), .CPU_RSP_OUT(CPU_RSP_OUT));

// ===== testbench/fspg_cpu_model.sv
// CPU core model that issues store-program and load-program requests.
`timescale 1ns/1ps
module fspg_cpu_model (
    // Clock.
    input  wire logic                    clk_in,
    // Request and response.
    output fspg_pkg::fspg_cpu_req_t      req_out,
    input  wire fspg_pkg::fspg_cpu_rsp_t rsp_in
);
    import fspg_pkg::*;
    initial req_out = '0;
    // One request at a time, and the program counter stays at the fetch word of the last request.
    task automatic issue(input logic st, input logic ld, input logic [12:0] fetch,
                         input logic [12:0] target, input logic [3:0] lk,
                         output fspg_cpu_rsp_t r);
        @(posedge clk_in);
        req_out <= {st, ld, target, fetch, lk};
        @(posedge clk_in);
        req_out.store_req <= 1'b0;
        req_out.load_req <= 1'b0;
        // A stale target would hide a design that samples late.
        req_out.target_word <= ~target;
        #1 r = rsp_in;
    endtask
endmodule // fspg_cpu_model

// ===== testbench/tb_top.sv
// Self-checking bench for the flash self-program guard.
`timescale 1ns/1ps
module tb_top;
    import fspg_pkg::*;
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    logic [1:0]    fuses = 2'h1;
    logic          vec_boot = 1'b1;
    logic [1:0]    gen_lock = 2'h0;
    logic [3:0]    addr = 4'h0;
    logic          rd = 1'b0;
    logic          wr = 1'b0;
    logic [31:0]   wdata = 32'h0000_0000;
    logic [31:0]   rdata;
    logic [31:0]   q;
    logic          wq;
    logic [3:0]    lk;
    fspg_cpu_req_t req;
    fspg_cpu_rsp_t rsp;
    fspg_cpu_rsp_t r;
    int            err_total = 0;
    int            n_tests = 0;

    always #25 clk = ~clk;

    fspg_guard dut_u (.CLK_SYS_IN(clk), .RESET_IN(rst), .BOOT_SIZE_FUSES_IN(fuses),
        .VECTORS_IN_BOOT_IN(vec_boot), .GENERAL_LOCK_MODE_IN(gen_lock), .CPU_REQ_IN(req),
        .CPU_RSP_OUT(rsp), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wq));
    fspg_cpu_model cpu_u (.clk_in(clk), .req_out(req), .rsp_in(rsp));

    task automatic stop_test();
        if (err_total == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Holds the request until waitrequest is seen low at a rising edge.
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 50);
        if (wq !== 1'b0) err_total++;
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    // The idle tail lets an unused arming lapse before the next control write.
    task automatic arm(input logic [31:0] c, input logic [12:0] f, input logic [12:0] t);
        bus(1'b1, REG_CTRL, c);
        cpu_u.issue(1'b1, 1'b0, f, t, lk, r);
        repeat (6) @(posedge clk);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        err_total++;
        stop_test();
    end

    initial begin
        lk = 4'hF;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, REG_LOCK, 32'h0000_0000);
        chk("lock reset", 32'h0000_000F, q);
        bus(1'b0, 4'hC, 32'h0000_0000);
        chk("unmapped read", UNMAPPED_DATA, q);
        fuses <= 2'h2;
        arm(32'h0000_0003, 13'h0_E10, 13'h0_100);
        chk("app store ignored", 1'b1, r.store_ignored);
        chk("app store erase", 1'b0, r.prog_erase);
        fuses <= 2'h1;
        for (int f = 0; f < 2; f++) begin
            for (int c = 0; c < 4; c++) begin
                bus(1'b1, REG_CTRL, 32'h0000_0080);
                lk = f ? {c[1:0], 2'h3} : {2'h3, c[1:0]};
                vec_boot <= (f == 0);
                arm(32'h0000_0009, 13'h0_E10, 13'h0_000);
                bus(1'b0, REG_LOCK, 32'h0000_0000);
                chk("lock field", {28'h0, lk}, q);
                cpu_u.issue(1'b0, 1'b1, f ? 13'h0_100 : 13'h0_E10, f ? 13'h0_E40 : 13'h0_100, lk, r);
                chk("load denied", !c[1], r.load_denied);
                cpu_u.issue(1'b0, 1'b0, f ? 13'h0_E10 : 13'h0_100, 13'h0_000, lk, r);
                chk("irq block", !c[1], r.irq_block);
                if (!c[0]) begin
                    arm(32'h0000_0003, 13'h0_E10, f ? 13'h0_E40 : 13'h0_100);
                    chk("locked store", 1'b1, r.store_ignored);
                    chk("locked erase", 1'b0, r.prog_erase);
                end
            end
        end
        lk = 4'h7;
        arm(32'h0000_0009, 13'h0_E10, 13'h0_000);
        lk = 4'hF;
        arm(32'h0000_0009, 13'h0_E10, 13'h0_000);
        bus(1'b0, REG_LOCK, 32'h0000_0000);
        chk("lock sticky", 32'h0000_0007, q);
        bus(1'b1, REG_CTRL, 32'h0000_0080);
        arm(32'h0000_0003, 13'h0_E10, 13'h0_100);
        chk("erase start", 1'b1, r.prog_erase);
        chk("cpu runs", 1'b0, r.cpu_stall);
        chk("halting readable", 1'b1, r.halting_read_ok);
        chk("concurrent blocked", 1'b0, r.concurrent_read_ok);
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        chk("busy status", 32'h0000_0003, q);
        for (int i = 0; i < 90 && q[1] !== 1'b0; i++) begin
            repeat (1000) @(posedge clk);
            bus(1'b0, REG_STATUS, 32'h0000_0000);
        end
        chk("busy after done", 32'h0000_0001, q);
        // Software clears the busy flag before it touches the concurrent section.
        arm(32'h0000_0011, 13'h0_E10, 13'h0_100);
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        chk("busy cleared", 32'h0000_0000, q);
        arm(32'h0000_0005, 13'h0_E10, 13'h0_E00);
        chk("stall", 1'b1, r.cpu_stall);
        chk("nothing readable", 1'b0, r.halting_read_ok);
        stop_test();
    end
endmodule // tb_top
